// ### src/cilr_params.svh
`ifndef CILR_PARAMS_SVH
`define CILR_PARAMS_SVH

// Register offsets on the serial control port
`define CILR_OFS_GENERAL_PIN_CONTROL      7'h06
`define CILR_OFS_AUDIO_LOOPBACK_CONTROL   7'h08
`define CILR_OFS_AUDIO_GAIN_CONTROL       7'h09
`define CILR_OFS_LINE_IMPEDANCE_CONTROL   7'h0A

// Reset values
`define CILR_RST_GENERAL_PIN_CONTROL      8'h00
`define CILR_RST_AUDIO_LOOPBACK_CONTROL   8'h02
`define CILR_RST_AUDIO_GAIN_CONTROL       8'h00
`define CILR_RST_LINE_IMPEDANCE_CONTROL   8'h08

// Implemented (writable) bits; all others are reserved
`define CILR_MSK_GENERAL_PIN_CONTROL      8'h1F
`define CILR_MSK_AUDIO_LOOPBACK_CONTROL   8'h07
`define CILR_MSK_AUDIO_GAIN_CONTROL       8'hFF
`define CILR_MSK_LINE_IMPEDANCE_CONTROL   8'h3F

// general_pin_control fields
`define CILR_BIT_DOUT                     4
`define CILR_BIT_SECOND_PIN_DIRECTION     3
`define CILR_BIT_FIRST_PIN_DIRECTION      2
`define CILR_BIT_SECOND_PIN_VALUE         1
`define CILR_BIT_FIRST_PIN_VALUE          0

// audio_loopback_control fields
`define CILR_BIT_FULL_ANALOG_LOOP_EN      2
`define CILR_BIT_DIGITAL_LOOP_EN          1
`define CILR_BIT_ANALOG_LOOP_EN           0

// audio_gain_control fields
`define CILR_BIT_RX_HIGHPASS_BYPASS       7
`define CILR_BIT_TX_HIGHPASS_BYPASS       6
`define CILR_BIT_TX_MUTE                  5
`define CILR_BIT_RX_MUTE                  4
`define CILR_POS_TX_ANALOG_GAIN           2
`define CILR_POS_RX_ANALOG_GAIN           0
`define CILR_GAIN_CODE_MUTE               2'h3

// line_impedance_control fields
`define CILR_POS_LINE_CAP_COMP            4
`define CILR_BIT_IMPEDANCE_SYNTH_EN       3
`define CILR_POS_IMPEDANCE_SYNTH_SEL      0

// Serial frame layout
`define CILR_CMD_READ_BIT                 7
`define CILR_CMD_LAST_BIT_CNT             5'h07
`define CILR_DATA_FIRST_BIT_CNT           5'h08
`define CILR_DATA_LAST_BIT_CNT            5'h0F

`endif

// ### src/cilr_pkg.sv
package cilr_pkg;

    typedef enum logic [1:0] {
        CILR_SPI_IDLE = 2'b00,
        CILR_SPI_CMD  = 2'b01,
        CILR_SPI_DATA = 2'b10,
        CILR_SPI_DONE = 2'b11
    } cilr_spi_state_t;

    typedef struct packed {
        logic       full_analog_loop_en;
        logic       digital_loop_en;
        logic       analog_loop_en;
        logic       rx_highpass_bypass;
        logic       tx_highpass_bypass;
        logic       tx_mute;
        logic       rx_mute;
        logic [1:0] tx_analog_gain;
        logic       tx_analog_mute;
        logic [1:0] rx_analog_gain;
        logic       rx_analog_mute;
        logic [1:0] line_cap_comp;
        logic       impedance_synth_en;
        logic [2:0] impedance_synth_sel;
    } cilr_audio_ctrl_t;

    typedef struct packed {
        logic dout;
        logic first_pin_value;
        logic first_pin_oe;
        logic second_pin_value;
        logic second_pin_oe;
    } cilr_pin_drive_t;

endpackage : cilr_pkg

// ### src/cilr_regs.sv
// Notes on behaviour
// - Dedicated output pin follows output data bit 4.
// - Second pin drives its data bit when direction bit 3 is one.
// - First pin drives its data bit when direction bit 2 is one.
// - Second pin as input: reading bit 1 returns the pin level.
// - First pin as input: reading bit 0 returns the pin level.
// - Bit 2 enables full analog loopback.
// - Bit 1 enables digital loopback; set after reset.
// - Bit 0 enables first analog loopback mode.
// - Bit 7 bypasses receive high-pass filter.
// - Bit 6 bypasses transmit high-pass filter.
// - Bit 5 digitally mutes transmit.
// - Bit 4 digitally mutes receive.
// - Transmit gain 0, -3.5, +3.5 dB; code 11 keeps 0 dB, mutes.
// - Receive gain 0, -3.5, +3.5 dB; code 11 mutes.
// - Bit 3 enables impedance synthesis; set after reset.
// - Three-bit field selects one of eight reference line impedances.
`timescale 1ns/1ps
`include "cilr_params.svh"
`default_nettype none

module cilr_regs (
    input  wire logic                       i_clk,
    input  wire logic                       i_rst_b,
    input  wire logic                       i_cs_b,
    input  wire logic                       i_sclk,
    input  wire logic                       i_sdi,
    output logic                            o_sdo,
    output logic                            o_sdo_oe,
    input  wire logic                       i_first_pin,
    input  wire logic                       i_second_pin,
    output cilr_pkg::cilr_pin_drive_t       o_pins,
    output cilr_pkg::cilr_audio_ctrl_t      o_audio
);
    import cilr_pkg::*;

    logic [7:0]      general_pin_control;
    logic [7:0]      audio_loopback_control;
    logic [7:0]      audio_gain_control;
    logic [7:0]      line_impedance_control;

    cilr_spi_state_t state;
    logic            sclk_q;
    logic [4:0]      bit_cnt;
    logic [7:0]      in_sr;
    logic [7:0]      out_sr;
    logic [6:0]      cmd_addr;
    logic            cmd_read;
    logic            wr_en;
    logic [6:0]      wr_addr;
    logic [7:0]      wr_data;
    logic            sclk_rise;
    logic            sclk_fall;
    logic [7:0]      next_byte;

    // Keeps only implemented bits so reserved ones stay zero
    function automatic logic [7:0] masked_write(input logic [7:0] d, input logic [7:0] m);
        masked_write = d & m;
    endfunction : masked_write

    function automatic logic [7:0] read_value(input logic [6:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (a == `CILR_OFS_GENERAL_PIN_CONTROL) begin
            v = general_pin_control;
            // Input pins report their live level instead of the stored bit
            if (!general_pin_control[`CILR_BIT_SECOND_PIN_DIRECTION]) begin
                v[`CILR_BIT_SECOND_PIN_VALUE] = i_second_pin;
            end
            if (!general_pin_control[`CILR_BIT_FIRST_PIN_DIRECTION]) begin
                v[`CILR_BIT_FIRST_PIN_VALUE] = i_first_pin;
            end
        end else if (a == `CILR_OFS_AUDIO_LOOPBACK_CONTROL) begin
            v = audio_loopback_control;
        end else if (a == `CILR_OFS_AUDIO_GAIN_CONTROL) begin
            v = audio_gain_control;
        end else if (a == `CILR_OFS_LINE_IMPEDANCE_CONTROL) begin
            v = line_impedance_control;
        end
        read_value = v; // Unmapped offsets read zero
    endfunction : read_value

    assign sclk_rise = i_sclk & ~sclk_q;
    assign sclk_fall = ~i_sclk & sclk_q;
    assign next_byte = {in_sr[6:0], i_sdi};

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sclk_q <= 1'b0;
        end else begin
            sclk_q <= i_sclk;
        end
    end

    // Serial frame: command byte (read flag, offset) then data byte, MSB first
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state    <= CILR_SPI_IDLE;
            bit_cnt  <= 5'h00;
            in_sr    <= 8'h00;
            cmd_addr <= 7'h00;
            cmd_read <= 1'b0;
        end else if (i_cs_b) begin
            // Chip select high aborts any partial frame
            state   <= CILR_SPI_IDLE;
            bit_cnt <= 5'h00;
        end else begin
            case (state)
                CILR_SPI_IDLE: begin
                    state <= CILR_SPI_CMD;
                end
                CILR_SPI_CMD: begin
                    if (sclk_rise) begin
                        in_sr   <= next_byte;
                        bit_cnt <= bit_cnt + 5'h01;
                        if (bit_cnt == `CILR_CMD_LAST_BIT_CNT) begin
                            state    <= CILR_SPI_DATA;
                            cmd_read <= next_byte[`CILR_CMD_READ_BIT];
                            cmd_addr <= next_byte[6:0];
                        end
                    end
                end
                CILR_SPI_DATA: begin
                    if (sclk_rise) begin
                        in_sr   <= next_byte;
                        bit_cnt <= bit_cnt + 5'h01;
                        if (bit_cnt == `CILR_DATA_LAST_BIT_CNT) begin
                            state <= CILR_SPI_DONE;
                        end
                    end
                end
                CILR_SPI_DONE: begin
                    // Extra clocks are ignored until chip select rises
                    state <= CILR_SPI_DONE;
                end
                default: begin
                    state <= CILR_SPI_IDLE;
                end
            endcase
        end
    end

    // One-cycle write strobe after the last data bit of a write frame
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wr_en   <= 1'b0;
            wr_addr <= 7'h00;
            wr_data <= 8'h00;
        end else begin
            wr_en <= !i_cs_b && state == CILR_SPI_DATA && sclk_rise && !cmd_read
                     && bit_cnt == `CILR_DATA_LAST_BIT_CNT;
            wr_addr <= cmd_addr;
            wr_data <= next_byte;
        end
    end

    // Read data loads after the command byte and shifts on falling clock
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            out_sr <= 8'h00;
        end else if (!i_cs_b && state == CILR_SPI_CMD && sclk_rise
                     && bit_cnt == `CILR_CMD_LAST_BIT_CNT) begin
            out_sr <= read_value(next_byte[6:0]);
        end else if (!i_cs_b && state == CILR_SPI_DATA && cmd_read && sclk_fall
                     && bit_cnt != `CILR_DATA_FIRST_BIT_CNT) begin
            // Fall closing the command byte must not shift: bit 7 waits for the next rise
            out_sr <= {out_sr[6:0], 1'b0};
        end
    end

    assign o_sdo    = out_sr[7];
    assign o_sdo_oe = !i_cs_b && state == CILR_SPI_DATA && cmd_read;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            general_pin_control <= `CILR_RST_GENERAL_PIN_CONTROL;
        end else if (wr_en && wr_addr == `CILR_OFS_GENERAL_PIN_CONTROL) begin
            general_pin_control <= masked_write(wr_data, `CILR_MSK_GENERAL_PIN_CONTROL);
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            audio_loopback_control <= `CILR_RST_AUDIO_LOOPBACK_CONTROL;
        end else if (wr_en && wr_addr == `CILR_OFS_AUDIO_LOOPBACK_CONTROL) begin
            audio_loopback_control <= masked_write(wr_data, `CILR_MSK_AUDIO_LOOPBACK_CONTROL);
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            audio_gain_control <= `CILR_RST_AUDIO_GAIN_CONTROL;
        end else if (wr_en && wr_addr == `CILR_OFS_AUDIO_GAIN_CONTROL) begin
            audio_gain_control <= masked_write(wr_data, `CILR_MSK_AUDIO_GAIN_CONTROL);
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            line_impedance_control <= `CILR_RST_LINE_IMPEDANCE_CONTROL;
        end else if (wr_en && wr_addr == `CILR_OFS_LINE_IMPEDANCE_CONTROL) begin
            line_impedance_control <= masked_write(wr_data, `CILR_MSK_LINE_IMPEDANCE_CONTROL);
        end
    end

    // Pin drive straight from the register bits
    always_comb begin
        o_pins.dout             = general_pin_control[`CILR_BIT_DOUT];
        o_pins.second_pin_oe    = general_pin_control[`CILR_BIT_SECOND_PIN_DIRECTION];
        o_pins.second_pin_value = general_pin_control[`CILR_BIT_SECOND_PIN_VALUE];
        o_pins.first_pin_oe     = general_pin_control[`CILR_BIT_FIRST_PIN_DIRECTION];
        o_pins.first_pin_value  = general_pin_control[`CILR_BIT_FIRST_PIN_VALUE];
    end

    // Datapath controls registered once so the analog side sees clean levels
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_audio <= '0;
        end else begin
            o_audio.full_analog_loop_en <=
                audio_loopback_control[`CILR_BIT_FULL_ANALOG_LOOP_EN];
            o_audio.digital_loop_en     <=
                audio_loopback_control[`CILR_BIT_DIGITAL_LOOP_EN];
            o_audio.analog_loop_en      <=
                audio_loopback_control[`CILR_BIT_ANALOG_LOOP_EN];
            o_audio.rx_highpass_bypass  <=
                audio_gain_control[`CILR_BIT_RX_HIGHPASS_BYPASS];
            o_audio.tx_highpass_bypass  <=
                audio_gain_control[`CILR_BIT_TX_HIGHPASS_BYPASS];
            o_audio.tx_mute             <= audio_gain_control[`CILR_BIT_TX_MUTE];
            o_audio.rx_mute             <= audio_gain_control[`CILR_BIT_RX_MUTE];
            // Mute code leaves the transmit stage at unity gain
            if (audio_gain_control[`CILR_POS_TX_ANALOG_GAIN +: 2] == `CILR_GAIN_CODE_MUTE) begin
                o_audio.tx_analog_gain <= 2'h0;
                o_audio.tx_analog_mute <= 1'b1;
            end else begin
                o_audio.tx_analog_gain <= audio_gain_control[`CILR_POS_TX_ANALOG_GAIN +: 2];
                o_audio.tx_analog_mute <= 1'b0;
            end
            o_audio.rx_analog_gain <= audio_gain_control[`CILR_POS_RX_ANALOG_GAIN +: 2];
            o_audio.rx_analog_mute <= audio_gain_control[`CILR_POS_RX_ANALOG_GAIN +: 2]
                                      == `CILR_GAIN_CODE_MUTE;
            o_audio.line_cap_comp       <= line_impedance_control[`CILR_POS_LINE_CAP_COMP +: 2];
            o_audio.impedance_synth_en  <=
                line_impedance_control[`CILR_BIT_IMPEDANCE_SYNTH_EN];
            o_audio.impedance_synth_sel <=
                line_impedance_control[`CILR_POS_IMPEDANCE_SYNTH_SEL +: 3];
        end
    end

endmodule : cilr_regs

`default_nettype wire

// ### test/cilr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module cilr_host_model (
    input  wire logic i_clk,
    output var logic  o_cs_b,
    output var logic  o_sclk,
    output var logic  o_sdi,
    input  wire logic i_sdo
);
    initial begin
        o_cs_b = 1'h1;
        o_sclk = 1'h0;
        o_sdi  = 1'h0;
    end
    // Sixteen-bit frame, mode 0; sclk stands still between frames
    task automatic frame(input logic rd, input logic [6:0] ofs, input logic [7:0] wd,
                         output logic [7:0] rdat);
        logic [15:0] sh;
        sh = {rd, ofs, wd};
        rdat = 8'h00;
        @(posedge i_clk) o_cs_b <= 1'h0;
        repeat (2) @(posedge i_clk);
        for (int i = 15; i >= 0; i--) begin
            o_sdi <= sh[i];
            repeat (2) @(posedge i_clk);
            o_sclk <= 1'h1;
            if (i < 8) rdat[i] = i_sdo;
            repeat (2) @(posedge i_clk);
            o_sclk <= 1'h0;
        end
        repeat (2) @(posedge i_clk);
        o_cs_b <= 1'h1;
        // Released line shows no stale bit
        o_sdi <= ~o_sdi;
        repeat (7) @(posedge i_clk);
    endtask : frame
endmodule : cilr_host_model
`default_nettype wire

// ### test/cilr_regs_properties.sv
`timescale 1ns/1ps
`default_nettype none
module cilr_regs_properties (
    input wire logic                      i_clk,
    input wire logic                      i_rst_b,
    input wire logic                      i_cs_b,
    input wire logic                      i_sclk,
    input wire logic                      i_sdi,
    input wire logic                      o_sdo,
    input wire logic                      o_sdo_oe,
    input wire logic                      i_first_pin,
    input wire logic                      i_second_pin,
    input wire cilr_pkg::cilr_pin_drive_t  o_pins,
    input wire cilr_pkg::cilr_audio_ctrl_t o_audio
);
    import cilr_pkg::*;
    logic [2:0] idle_cnt;
    logic [4:0] rise_cnt;
    logic       sclk_q;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    // Long chip-select idle: no write can be in flight
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) idle_cnt <= 3'h0;
        else if (!i_cs_b) idle_cnt <= 3'h0;
        else if (idle_cnt != 3'h7) idle_cnt <= idle_cnt + 3'h1;
    end
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) sclk_q <= 1'h0;
        else sclk_q <= i_sclk;
    end
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) rise_cnt <= 5'h00;
        else if (i_cs_b) rise_cnt <= 5'h00;
        else if (i_sclk && !sclk_q && rise_cnt != 5'h1F) rise_cnt <= rise_cnt + 5'h01;
    end
    a_tx_mute_zero: assert property (
        o_audio.tx_analog_mute |-> o_audio.tx_analog_gain == 2'h0)
        else $error("tx analog mute without 0 dB gain");
    a_tx_no_code3: assert property (
        !o_audio.tx_analog_mute |-> o_audio.tx_analog_gain != 2'h3)
        else $error("tx gain code 3 passed unmuted");
    a_rx_mute_code: assert property (
        o_audio.rx_analog_mute == (o_audio.rx_analog_gain == 2'h3))
        else $error("rx analog mute does not follow code 3");
    a_pins_quiet: assert property (
        idle_cnt >= 3'h4 |-> $stable(o_pins))
        else $error("pin drive changed with no frame");
    a_audio_quiet: assert property (
        idle_cnt >= 3'h5 |-> $stable(o_audio))
        else $error("audio controls changed with no frame");
    a_sdo_idle: assert property (
        idle_cnt >= 3'h3 |-> !o_sdo_oe)
        else $error("data out driven while deselected");
    a_sdo_start: assert property (
        $rose(o_sdo_oe) |-> rise_cnt == 5'h08 && !i_cs_b)
        else $error("data out enabled away from command end");
    a_reset_sets: assert property (
        $past(!i_rst_b) |-> ##1 o_audio.digital_loop_en && o_audio.impedance_synth_en)
        else $error("reset defaults missing on audio controls");
endmodule : cilr_regs_properties
bind cilr_regs cilr_regs_properties i_cilr_regs_properties (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_cs_b(i_cs_b), .i_sclk(i_sclk),
    .i_sdi(i_sdi), .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe), .i_first_pin(i_first_pin),
    .i_second_pin(i_second_pin), .o_pins(o_pins), .o_audio(o_audio));
`default_nettype wire

// ### test/cilr_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "cilr_params.svh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module cilr_regs_test;
    import cilr_pkg::*;
    logic             i_clk, i_rst_b, cs_b, sclk, sdi, sdo, sdo_oe, ext_first, ext_second;
    wire logic        first_w, second_w, sdo_w;
    cilr_pin_drive_t  pins;
    cilr_audio_ctrl_t audio;
    int               mismatches, compares, cycles;
    logic [6:0]       ofs [4] = '{`CILR_OFS_GENERAL_PIN_CONTROL, `CILR_OFS_AUDIO_LOOPBACK_CONTROL,
                                  `CILR_OFS_AUDIO_GAIN_CONTROL, `CILR_OFS_LINE_IMPEDANCE_CONTROL};
    logic [7:0]       rstv [4] = '{8'h00, 8'h02, 8'h00, 8'h08};
    logic [7:0]       mask [4] = '{8'h1F, 8'h07, 8'hFF, 8'h3F};
    // Wire level resolved from the device enable and the far driver
    assign first_w  = pins.first_pin_oe ? pins.first_pin_value : ext_first;
    assign second_w = pins.second_pin_oe ? pins.second_pin_value : ext_second;
    // Undriven data line shows the inverse, so a late enable corrupts the read
    assign sdo_w    = sdo_oe ? sdo : ~sdo;
    cilr_regs i_cilr_regs (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_cs_b(cs_b), .i_sclk(sclk),
        .i_sdi(sdi), .o_sdo(sdo), .o_sdo_oe(sdo_oe), .i_first_pin(first_w),
        .i_second_pin(second_w), .o_pins(pins), .o_audio(audio));
    cilr_host_model i_cilr_host_model (.i_clk(i_clk), .o_cs_b(cs_b), .o_sclk(sclk),
        .o_sdi(sdi), .i_sdo(sdo_w));
    task automatic complete_run;
        if (mismatches == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : complete_run
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] x;
        i_cilr_host_model.frame(1'h0, a, d, x);
    endtask : wr
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        i_cilr_host_model.frame(1'h1, a, 8'h00, d);
    endtask : rd
    task automatic t_reset;
        logic [7:0] d;
        `CHK("dig_loop", 1'h1, audio.digital_loop_en)
        `CHK("synth_en", 1'h1, audio.impedance_synth_en)
        `CHK("pins", 5'h00, pins)
        for (int i = 0; i < 4; i++) begin
            rd(ofs[i], d);
            `CHK("reset_val", rstv[i], d)
        end
    endtask : t_reset
    task automatic t_reserved;
        logic [7:0] d;
        for (int i = 0; i < 4; i++) begin
            wr(ofs[i], 8'hFF);
            rd(ofs[i], d);
            `CHK("masked", mask[i], d)
        end
        `CHK("pins_all", 5'h1F, pins)
        wr(7'h07, 8'hFF);
        rd(7'h07, d);
        `CHK("unmapped", 8'h00, d)
    endtask : t_reserved
    task automatic t_pins;
        logic [7:0] d;
        wr(`CILR_OFS_GENERAL_PIN_CONTROL, 8'h10);
        @(posedge i_clk) ext_first <= 1'h1;
        rd(`CILR_OFS_GENERAL_PIN_CONTROL, d);
        `CHK("pins_in1", 8'h11, d)
        `CHK("dout_only", 5'h10, pins)
        ext_first <= 1'h0;
        ext_second <= 1'h1;
        rd(`CILR_OFS_GENERAL_PIN_CONTROL, d);
        `CHK("pins_in2", 8'h12, d)
        wr(`CILR_OFS_GENERAL_PIN_CONTROL, 8'h0A);
        `CHK("second_out", 5'h03, pins)
        @(posedge i_clk) ext_first <= 1'h1;
        rd(`CILR_OFS_GENERAL_PIN_CONTROL, d);
        `CHK("mix_a", 8'h0B, d)
        wr(`CILR_OFS_GENERAL_PIN_CONTROL, 8'h05);
        `CHK("first_out", 5'h0C, pins)
        rd(`CILR_OFS_GENERAL_PIN_CONTROL, d);
        `CHK("mix_b", 8'h07, d)
    endtask : t_pins
    task automatic t_loop;
        for (int b = 0; b < 3; b++) begin
            wr(`CILR_OFS_AUDIO_LOOPBACK_CONTROL, 8'h01 << b);
            `CHK("loops", 3'h1 << b, {audio.full_analog_loop_en, audio.digital_loop_en,
                audio.analog_loop_en})
        end
    endtask : t_loop
    task automatic t_gain;
        logic [1:0] c;
        logic [7:0] v;
        for (int k = 0; k < 4; k++) begin
            c = 2'(k);
            v = {4'h1 << k, c, c};
            wr(`CILR_OFS_AUDIO_GAIN_CONTROL, v);
            `CHK("hp_mute", v[7:4], {audio.rx_highpass_bypass, audio.tx_highpass_bypass,
                audio.tx_mute, audio.rx_mute})
            `CHK("tx_gain", (c == 2'h3) ? 3'h1 : {c, 1'h0}, {audio.tx_analog_gain,
                audio.tx_analog_mute})
            `CHK("rx_gain", {c, c == 2'h3}, {audio.rx_analog_gain, audio.rx_analog_mute})
        end
    endtask : t_gain
    task automatic t_imp;
        logic [7:0] v;
        for (int k = 0; k < 8; k++) begin
            v = {2'h0, 2'(k), k[0], 3'(k)};
            wr(`CILR_OFS_LINE_IMPEDANCE_CONTROL, v);
            `CHK("synth", v[5:0], {audio.line_cap_comp, audio.impedance_synth_en,
                audio.impedance_synth_sel})
        end
    endtask : t_imp
    initial begin
        i_clk = 1'h0;
        forever #5 i_clk = ~i_clk;
    end
    // Whole run needs some 2750 cycles
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            complete_run();
        end
    end
    initial begin
        i_rst_b = 1'h0;
        ext_first = 1'h0;
        ext_second = 1'h0;
        repeat (6) @(posedge i_clk);
        i_rst_b <= 1'h1;
        repeat (3) @(posedge i_clk);
        t_reset();
        t_reserved();
        t_pins();
        t_loop();
        t_gain();
        t_imp();
        complete_run();
    end
endmodule : cilr_regs_test
`undef CHK
`default_nettype wire
